// File: hw/gdc_cfg.svh
// Offsets, reset values and timing counts of the gate driver control
`ifndef GDC_CFG_SVH
`define GDC_CFG_SVH
`define GDC_OFF_CTRL 8'h00
`define GDC_OFF_STATUS 8'h04
`define GDC_OFF_FCOUNT 8'h08
`define GDC_OFF_LEVEL 8'h0c
`define GDC_CTRL_RST 2'h3
`define GDC_CTRL_SWEN 0
`define GDC_CTRL_MONEN 1
`define GDC_CLK_PERIOD_NS 100
`define GDC_CLK_FREQ_KHZ 10000
`define GDC_MON_FREQ_KHZ 400
`define GDC_MON_PERIOD_CYC (`GDC_CLK_FREQ_KHZ / `GDC_MON_FREQ_KHZ)
`define GDC_DUTY_MIN_PCT 5
`define GDC_DUTY_MAX_PCT 95
`define GDC_DEGLITCH_NS 40
`define GDC_DEGLITCH_CYC ((`GDC_DEGLITCH_NS + `GDC_CLK_PERIOD_NS - 1) / `GDC_CLK_PERIOD_NS)
`define GDC_RST_FILTER_CYC 20
`define GDC_MUTE_CYC 200
`define GDC_SOFTOFF_CYC 10
`endif

// File: hw/gdc_ctrl.sv
// Gate driver control core: gating, fault latch, lockout, register slave
// How it works
// - Overcurrent while on pulls fault alarm low until accepted reset.
// - Reset requests during the fault mute interval are ignored.
// - Enable held low past filter time clears fault on its rising edge.
// - Enable low disables the driver, gate off by normal turn-off.
// - Undriven enable reads low, so the driver starts disabled.
// - Forced-on with output supplies up drives gate high, clamp low, alarm off.
// - Forced-on level reported as fixed-rate PWM, duty 5 to 95 percent.
// - Outside forced-on, gate high only with supplies up, IN+ high, IN- low, enable high.
// - Supplies up above upper thresholds, down below lower ones.
// - Any lockout pulls ready low; gate held low except input-side lockout under forced-on.
// - Leaving lockout releases ready and resumes following the inputs.
// - After fault the gate stays off until accepted reset.
// - Pulses shorter than the deglitch width are rejected on three inputs.
// - Both PWM inputs high holds the gate low.
// - Fault starts soft turn-off then holds gate low until reset.
`timescale 1ns/1ps
`include "gdc_cfg.svh"
module gdc_ctrl
    import gdc_pkg::*;
#(
    parameter int RST_FILTER_CYC = `GDC_RST_FILTER_CYC,
    parameter int MUTE_CYC = `GDC_MUTE_CYC,
    parameter int SOFTOFF_CYC = `GDC_SOFTOFF_CYC,
    parameter int DEGLITCH_CYC = `GDC_DEGLITCH_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control pins
    input wire logic pwmInP,
    input wire logic pwmInN,
    input wire logic rstEnIn,
    input wire logic force_on_input,
    input wire logic [7:0] forceLevelCode,
    input wire logic overcurrent_sense,
    // Supply comparators: bit 0 input side, 1 positive out, 2 negative out
    input wire logic [2:0] supAboveUpper,
    input wire logic [2:0] supBelowLower,
    // Gate side
    output logic gate_drive_out,
    output logic miller_clamp_drive,
    output logic softOffActive,
    // Open-drain status pins and push-pull level monitor output
    output logic fault_alarm_n,
    output logic faultAlarmOe,
    output logic readyOut,
    output logic readyOe,
    output logic force_level_monitor,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int FW = $clog2(RST_FILTER_CYC + 1);
    localparam int TW = $clog2(MUTE_CYC + SOFTOFF_CYC + 1);
    // Cycles from the eighth soft-off cycle to the first mute cycle
    localparam int SOFT_TAIL = SOFTOFF_CYC - 7;

    gdc_fault_e state_r;
    logic [2:0] inF;
    logic [3:0] rawF;
    logic pwmP, pwmN, rstEn, forceOn, ocDet;
    logic [7:0] level_r;
    logic [2:0] supUp_r;
    logic [2:0] supBelowS, supAboveS;
    logic allUp, outUp, forceActive, faultLatched, normalOn;
    logic rstEnPrev_r;
    logic [FW-1:0] lowCnt_r;
    logic resetArmed, resetAccept;
    logic [TW-1:0] tmr_r;
    logic [1:0] ctrl_r;
    logic [15:0] faultCount_r;
    logic [7:0] awAddr_r;
    logic awHeld_r, wHeld_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic swEnable;

    gdc_mon_if monLink ();

    // Pin filters; enable resets low so an undriven pin keeps the driver off
    gdc_deglitch #(.W(3), .CNT(DEGLITCH_CYC), .RST_VAL(3'b000)) uPwmFilt (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({rstEnIn, pwmInN, pwmInP}),
        .dout(inF)
    );
    gdc_deglitch #(.W(4), .CNT(1), .RST_VAL(4'b0000)) uRawSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({overcurrent_sense, force_on_input, 2'b00}),
        .dout(rawF)
    );
    gdc_deglitch #(.W(8), .CNT(1), .RST_VAL(8'h00)) uLevelSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(forceLevelCode),
        .dout(level_r)
    );
    gdc_deglitch #(.W(6), .CNT(1), .RST_VAL(6'h00)) uSupSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({supBelowLower, supAboveUpper}),
        .dout({supBelowS, supAboveS})
    );

    assign pwmP = inF[0];
    assign pwmN = inF[1];
    assign rstEn = inF[2];
    assign forceOn = rawF[2];
    assign ocDet = rawF[3];

    // Hysteresis: set above upper threshold, clear below lower threshold
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            supUp_r <= 3'b000;
        end else begin
            supUp_r <= (supUp_r | supAboveS) & ~supBelowS;
        end
    end

    assign allUp = &supUp_r;
    assign outUp = supUp_r[1] & supUp_r[2];
    assign forceActive = forceOn & outUp;
    assign faultLatched = (state_r != GDC_IDLE);
    assign swEnable = ctrl_r[`GDC_CTRL_SWEN];
    assign normalOn = allUp & pwmP & ~pwmN & rstEn & swEnable & ~faultLatched;

    // Gate and clamp drive
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_drive_out <= 1'b0;
            miller_clamp_drive <= 1'b0;
        end else if (forceActive) begin
            gate_drive_out <= 1'b1;
            miller_clamp_drive <= 1'b0;
        end else begin
            gate_drive_out <= normalOn;
            miller_clamp_drive <= ~normalOn & supUp_r[1];
        end
    end

    // Fault sequence: soft turn-off, mute, latched until accepted reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= GDC_IDLE;
            tmr_r <= '0;
        end else begin
            case (state_r)
                GDC_IDLE: begin
                    tmr_r <= '0;
                    if (ocDet && gate_drive_out && !forceActive) begin
                        state_r <= GDC_SOFTOFF;
                    end
                end
                GDC_SOFTOFF: begin
                    tmr_r <= tmr_r + 1'b1;
                    if (tmr_r == TW'(SOFTOFF_CYC - 1)) begin
                        state_r <= GDC_MUTE;
                    end
                end
                GDC_MUTE: begin
                    tmr_r <= tmr_r + 1'b1;
                    if (tmr_r == TW'(SOFTOFF_CYC + MUTE_CYC - 1)) begin
                        state_r <= GDC_LATCHED;
                    end
                end
                GDC_LATCHED: begin
                    if (resetAccept) begin
                        state_r <= GDC_IDLE;
                    end
                end
                default: state_r <= GDC_IDLE;
            endcase
        end
    end

    // Reset filter counts only once the mute interval is over
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lowCnt_r <= '0;
            rstEnPrev_r <= 1'b0;
        end else begin
            rstEnPrev_r <= rstEn;
            if (state_r != GDC_LATCHED || rstEn) begin
                if (rstEn && rstEnPrev_r) begin
                    lowCnt_r <= '0;
                end
                if (state_r != GDC_LATCHED) begin
                    lowCnt_r <= '0;
                end
            end else if (lowCnt_r != FW'(RST_FILTER_CYC)) begin
                lowCnt_r <= lowCnt_r + 1'b1;
            end
        end
    end

    assign resetArmed = (lowCnt_r == FW'(RST_FILTER_CYC));
    assign resetAccept = resetArmed && rstEn && !rstEnPrev_r;

    // Open-drain pins: the pin value is always low, the enable pulls it
    assign fault_alarm_n = 1'b0;
    assign faultAlarmOe = faultLatched & ~forceActive;
    assign readyOut = 1'b0;
    assign readyOe = ~allUp;
    assign softOffActive = (state_r == GDC_SOFTOFF);

    // Level monitor
    assign monLink.level = level_r;
    assign monLink.enable = ctrl_r[`GDC_CTRL_MONEN];
    assign force_level_monitor = monLink.pwmOut;
    gdc_level_mon #(.PERIOD(`GDC_MON_PERIOD_CYC)) uMon (
        .clk(clk),
        .sys_rst(sys_rst),
        .mon(monLink.gen)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            faultCount_r <= '0;
        end else if (state_r == GDC_IDLE && ocDet && gate_drive_out && !forceActive) begin
            faultCount_r <= faultCount_r + 16'h0001;
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            ctrl_r <= `GDC_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ({awAddr_r[7:2], 2'b00} == `GDC_OFF_CTRL) begin
                    s_axi_bresp <= 2'b00;
                    if (wStrb_r[0]) begin
                        ctrl_r <= wData_r[1:0];
                    end
                end else if ({awAddr_r[7:2], 2'b00} == `GDC_OFF_STATUS ||
                             {awAddr_r[7:2], 2'b00} == `GDC_OFF_FCOUNT ||
                             {awAddr_r[7:2], 2'b00} == `GDC_OFF_LEVEL) begin
                    s_axi_bresp <= 2'b00;
                end else begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case ({s_axi_araddr[7:2], 2'b00})
                `GDC_OFF_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
                `GDC_OFF_STATUS: s_axi_rdata <= {23'h0, state_r, supUp_r, forceActive,
                                                 rstEn, gate_drive_out, faultLatched};
                `GDC_OFF_FCOUNT: s_axi_rdata <= {16'h0, faultCount_r};
                `GDC_OFF_LEVEL: s_axi_rdata <= {24'h0, level_r};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    a_alarm_held: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(faultLatched) && !forceActive |=> faultAlarmOe [*8])
        else $error("fault alarm released too early");
    a_mute_ignore: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == GDC_MUTE |-> !resetAccept && lowCnt_r == '0)
        else $error("reset counted during mute");
    a_reset_clear: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == GDC_LATCHED && resetArmed && $rose(rstEn) |=> state_r == GDC_IDLE)
        else $error("accepted reset did not clear fault");
    a_enable_off: assert property (@(posedge clk) disable iff (sys_rst)
        !rstEn && !forceActive |=> !gate_drive_out)
        else $error("gate on while disabled");
    a_force_on: assert property (@(posedge clk) disable iff (sys_rst)
        forceActive |=> gate_drive_out && !miller_clamp_drive && !faultAlarmOe)
        else $error("forced-on not honoured");
    a_normal_on: assert property (@(posedge clk) disable iff (sys_rst)
        !forceActive && allUp && pwmP && !pwmN && rstEn && swEnable && !faultLatched
        |=> gate_drive_out)
        else $error("gate not driven in normal on state");
    a_lockout: assert property (@(posedge clk) disable iff (sys_rst)
        !allUp |-> readyOe ##1 (forceActive || $past(forceActive) || !gate_drive_out))
        else $error("lockout did not hold gate off");
    a_interlock: assert property (@(posedge clk) disable iff (sys_rst)
        pwmP && pwmN && !forceActive |=> !gate_drive_out)
        else $error("shoot-through interlock failed");
    a_softoff_len: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(softOffActive) |-> softOffActive [*8] ##SOFT_TAIL state_r == GDC_MUTE)
        else $error("soft turn-off length wrong");
    a_fault_off: assert property (@(posedge clk) disable iff (sys_rst)
        faultLatched && $past(faultLatched) && !forceActive |=> !gate_drive_out)
        else $error("gate on while fault latched");
endmodule

// File: hw/gdc_deglitch.sv
// Two-flop synchroniser followed by a stable-count pulse filter per bit
`timescale 1ns/1ps
module gdc_deglitch #(
    parameter int W = 1,
    parameter int CNT = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Raw and filtered levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    localparam int CW = $clog2(CNT + 1);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [CW-1:0] cnt_r;
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                cnt_r <= '0;
                dout[i] <= RST_VAL[i];
            end else if (sync_r[i] == dout[i]) begin
                cnt_r <= '0;
            end else if (cnt_r >= CW'(CNT)) begin
                cnt_r <= '0;
                dout[i] <= sync_r[i];
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule

// File: hw/gdc_level_mon.sv
// Fixed-rate PWM encoder of the forced-on input level
`timescale 1ns/1ps
`include "gdc_cfg.svh"
module gdc_level_mon
    import gdc_pkg::*;
#(
    parameter int PERIOD = `GDC_MON_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Level in, PWM out
    gdc_mon_if.gen mon
);
    logic [7:0] phase_r;
    logic [7:0] high_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= '0;
            high_r <= '0;
        end else if (phase_r == 8'(PERIOD - 1)) begin
            phase_r <= '0;
            high_r <= gdcDutyHigh(mon.level, PERIOD, `GDC_DUTY_MIN_PCT, `GDC_DUTY_MAX_PCT);
        end else begin
            phase_r <= phase_r + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mon.pwmOut <= 1'b0;
        end else begin
            mon.pwmOut <= mon.enable && (phase_r < high_r);
        end
    end
endmodule

// File: hw/gdc_mon_if.sv
// Link between the control core and the level monitor generator
`timescale 1ns/1ps
interface gdc_mon_if;
    logic [7:0] level;
    logic enable;
    logic pwmOut;
    modport ctrl (output level, output enable, input pwmOut);
    modport gen (input level, input enable, output pwmOut);
endinterface

// File: hw/gdc_pkg.sv
// Types and shared arithmetic of the gate driver control
package gdc_pkg;
    typedef enum logic [1:0] {
        GDC_IDLE = 2'b00,
        GDC_SOFTOFF = 2'b01,
        GDC_MUTE = 2'b10,
        GDC_LATCHED = 2'b11
    } gdc_fault_e;

    // High cycles of one monitor period for an 8-bit level, 5 % to 95 %
    function automatic logic [7:0] gdcDutyHigh(input logic [7:0] level, input int period,
                                                input int minPct, input int maxPct);
        int num;
        num = period * (minPct * 255 + (maxPct - minPct) * int'(level));
        return 8'(num / (100 * 255));
    endfunction
endpackage

// File: testbench/gdc_host_model.sv
// Host-side model: pin drivers, enable pulldown and status pull-ups
`timescale 1ns/1ps
module gdc_host_model (
    // Levels the host wants on its outputs
    input wire logic wantP,
    input wire logic wantN,
    input wire logic wantEn,
    input wire logic enDrive,
    // Pins towards the driver
    output logic pwmInP,
    output logic pwmInN,
    output logic rstEnIn,
    // Open-drain status lines
    input wire logic faultAlarmOe,
    input wire logic readyOe,
    output logic faultPin,
    output logic readyPin
);
    assign pwmInP = wantP;
    assign pwmInN = wantN;
    // An undriven enable falls to its pulldown
    assign rstEnIn = enDrive ? wantEn : 1'b0;
    // Released lines rest at the pull-up level
    assign faultPin = faultAlarmOe ? 1'b0 : 1'b1;
    assign readyPin = readyOe ? 1'b0 : 1'b1;
endmodule

// File: testbench/isolated_gate_driver_control_tb_top.sv
// Self-checking bench of the gate driver control core
`timescale 1ns/1ps
`include "gdc_cfg.svh"
module isolated_gate_driver_control_tb_top;
    localparam int RF = 5;
    localparam int MC = 20;
    localparam int SC = 10;
    logic clk, sys_rst, wantP, wantN, wantEn, enDrive, pwmInP, pwmInN, rstEnIn;
    logic force_on_input, overcurrent_sense, gate_drive_out, miller_clamp_drive;
    logic softOffActive, fault_alarm_n, faultAlarmOe, readyOut, readyOe;
    logic force_level_monitor, faultPin, readyPin, prev;
    logic [7:0] forceLevelCode, s_axi_awaddr, s_axi_araddr;
    logic [2:0] supAboveUpper, supBelowLower;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] lv [3] = '{8'h00, 8'h80, 8'hff};
    int num_errors = 0;
    int cmp_count = 0;
    int hi, ed, ex;

    gdc_ctrl #(.RST_FILTER_CYC(RF), .MUTE_CYC(MC), .SOFTOFF_CYC(SC), .DEGLITCH_CYC(1)) dut (
        .clk, .sys_rst, .pwmInP, .pwmInN, .rstEnIn, .force_on_input, .forceLevelCode,
        .overcurrent_sense, .supAboveUpper, .supBelowLower, .gate_drive_out,
        .miller_clamp_drive, .softOffActive, .fault_alarm_n, .faultAlarmOe, .readyOut,
        .readyOe, .force_level_monitor, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    gdc_host_model host (.wantP, .wantN, .wantEn, .enDrive, .pwmInP, .pwmInN, .rstEnIn,
        .faultAlarmOe, .readyOe, .faultPin, .readyPin);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pins(input logic p, input logic n, input logic en);
        @(posedge clk);
        wantP <= p;
        wantN <= n;
        wantEn <= en;
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic finish_test;
        $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs about 800 cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    initial begin
        {wantP, wantN, wantEn, enDrive, force_on_input, overcurrent_sense} = 6'h00;
        {forceLevelCode, supAboveUpper, supBelowLower} = 14'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_wstrb = 4'hf;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        tick(1);
        check(gate_drive_out, 1'b0);
        check(readyPin, 1'b0);
        check(faultPin, 1'b1);
        check(fault_alarm_n, 1'b0);
        check(readyOut, 1'b0);
        axiRead(`GDC_OFF_CTRL, rd, resp);
        check(rd, `GDC_CTRL_RST);
        axiRead(8'h40, rd, resp);
        check(rd, 32'h0);
        check(resp, 2'b10);
        axiWrite(8'h40, 32'h0, resp);
        check(resp, 2'b10);
        axiWrite(`GDC_OFF_FCOUNT, 32'hffff, resp);
        check(resp, 2'b00);
        $display("Test registers done");

        @(posedge clk);
        supAboveUpper <= 3'h7;
        pins(1'b1, 1'b0, 1'b1);
        tick(8);
        check(gate_drive_out, 1'b0);
        check(readyPin, 1'b1);
        @(posedge clk);
        enDrive <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pins(i[0], i[1], 1'b1);
            tick(8);
            check(gate_drive_out, i == 1);
            check(miller_clamp_drive, i != 1);
        end
        pins(1'b1, 1'b0, 1'b0);
        tick(8);
        check(gate_drive_out, 1'b0);
        axiWrite(`GDC_OFF_CTRL, 32'h2, resp);
        pins(1'b1, 1'b0, 1'b1);
        tick(8);
        check(gate_drive_out, 1'b0);
        axiWrite(`GDC_OFF_CTRL, 32'h3, resp);
        tick(4);
        check(gate_drive_out, 1'b1);
        $display("Test gating done");

        @(posedge clk);
        supAboveUpper <= 3'h0;
        tick(8);
        check(readyPin, 1'b1);
        for (int b = 0; b < 3; b++) begin
            @(posedge clk);
            supAboveUpper <= 3'h7 & ~(3'h1 << b);
            supBelowLower <= 3'h1 << b;
            tick(8);
            check(gate_drive_out, 1'b0);
            check(readyPin, 1'b0);
            @(posedge clk);
            supBelowLower <= 3'h0;
            tick(8);
            check(readyPin, 1'b0);
            @(posedge clk);
            supAboveUpper <= 3'h7;
            tick(8);
            check(gate_drive_out, 1'b1);
            check(readyPin, 1'b1);
        end
        $display("Test lockout done");

        @(posedge clk);
        overcurrent_sense <= 1'b1;
        tick(7);
        check(softOffActive, 1'b1);
        check(faultPin, 1'b0);
        check(gate_drive_out, 1'b0);
        @(posedge clk);
        overcurrent_sense <= 1'b0;
        pins(1'b1, 1'b0, 1'b0);
        tick(RF + 4);
        pins(1'b1, 1'b0, 1'b1);
        tick(SC + MC + 10);
        check(faultPin, 1'b0);
        check(gate_drive_out, 1'b0);
        axiRead(`GDC_OFF_STATUS, rd, resp);
        check(rd[0], 1'b1);
        axiRead(`GDC_OFF_FCOUNT, rd, resp);
        check(rd[15:0], 16'h1);
        pins(1'b1, 1'b0, 1'b0);
        tick(RF + 4);
        check(faultPin, 1'b0);
        pins(1'b1, 1'b0, 1'b1);
        tick(8);
        check(faultPin, 1'b1);
        check(gate_drive_out, 1'b1);
        $display("Test fault done");

        pins(1'b0, 1'b0, 1'b0);
        @(posedge clk);
        force_on_input <= 1'b1;
        supAboveUpper <= 3'h6;
        supBelowLower <= 3'h1;
        tick(8);
        check(gate_drive_out, 1'b1);
        check(miller_clamp_drive, 1'b0);
        check(faultPin, 1'b1);
        @(posedge clk);
        force_on_input <= 1'b0;
        tick(8);
        check(gate_drive_out, 1'b0);
        $display("Test forced-on done");

        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            forceLevelCode <= lv[k];
            tick(60);
            ex = (`GDC_MON_PERIOD_CYC * (5 * 255 + 90 * int'(lv[k]))) / 25500;
            hi = 0;
            ed = 0;
            prev = force_level_monitor;
            repeat (100) begin
                tick(1);
                hi += int'(force_level_monitor === 1'b1);
                ed += int'(force_level_monitor === 1'b1 && prev === 1'b0);
                prev = force_level_monitor;
            end
            check(hi, 4 * ex);
            check(ed, 4);
        end
        $display("Test monitor done");
        finish_test();
    end
endmodule
